// *** pkg/pmd_pkg.sv ***
// pmd_pkg: constants, register map, types of the power-mode manager.
// assumes one 125 MHz clock; figures in cycles derive from the times below.
package pmd_pkg;
  localparam int CLK_MHZ = 125;
  localparam int CLK_KHZ = 125000;
  localparam int CORE_MHZ = 25;
  localparam int CORE_DIV = CLK_MHZ / CORE_MHZ;
  localparam int RUN_FRAME_MS = 8;
  localparam int RUN_FRAME_TICKS = RUN_FRAME_MS * CORE_MHZ * 1000;
  localparam int HIB_TICK_MS = 10;
  localparam int HIB_TICK_CYCLES = HIB_TICK_MS * CLK_KHZ;
  localparam int SELFTEST_MS = 250;
  localparam int SELFTEST_CYCLES = SELFTEST_MS * CLK_KHZ;

  localparam logic [7:0] ADDR_RESULT0 = 8'h0c;
  localparam logic [7:0] ADDR_RESULT3 = 8'h0f;
  localparam logic [7:0] ADDR_SELFTEST = 8'h10;
  localparam logic [7:0] ADDR_BUTTON = 8'h12;
  localparam logic [7:0] ADDR_RUN_TMO = 8'h13;
  localparam logic [7:0] ADDR_R1_PER = 8'h14;
  localparam logic [7:0] ADDR_R1_TMO = 8'h15;
  localparam logic [7:0] ADDR_R2_PER = 8'h16;
  localparam logic [7:0] ADDR_R2_TMO = 8'h17;
  localparam logic [7:0] ADDR_R3_PER = 8'h18;

  localparam int SELFTEST_GO_BIT = 0;
  localparam int BTN_LEVEL_BIT = 0;
  localparam int BTN_FALL_LSB = 4;
  localparam int BTN_RISE_LSB = 6;

  localparam logic [7:0] RST_RUN_TMO = 8'h04;
  localparam logic [7:0] RST_R1_PER = 8'h01;
  localparam logic [7:0] RST_R1_TMO = 8'h1f;
  localparam logic [7:0] RST_R2_PER = 8'h09;
  localparam logic [7:0] RST_R2_TMO = 8'h2f;
  localparam logic [7:0] RST_R3_PER = 8'h31;

  localparam logic [7:0] PER_MIN = 8'h01;
  localparam logic [7:0] PER_MAX = 8'hf0;
  localparam logic [7:0] RUN_TMO_MIN = 8'h02;
  localparam logic [7:0] REST_TMO_MIN = 8'h01;
  localparam logic [7:0] TMO_MAX = 8'hf2;
  localparam logic [15:0] RUN_MULT = 16'h0008;
  localparam logic [15:0] R1_MULT = 16'h0010;
  localparam logic [15:0] R2_MULT = 16'h0080;

  localparam logic [7:0] SIG_BYTE0 = 8'h3e;
  localparam logic [7:0] SIG_BYTE1 = 8'h5c;
  localparam logic [7:0] SIG_BYTE2 = 8'ha4;
  localparam logic [7:0] SIG_BYTE3 = 8'h24;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP1 = 2'b01,
    MODE_SLEEP2 = 2'b10,
    MODE_SLEEP3 = 2'b11
  } pmd_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_WRITE = 2'b10
  } pmd_st_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmd_reg_req_t;
endpackage : pmd_pkg

// *** design/pmd_result_mem.sv ***
// pmd_result_mem: small store of self-test result bytes.
// assumes one writer and one reader on the same clock; read data registered.
`timescale 1ns/1ps
module pmd_result_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem_ff [DEPTH];

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_ff[i] <= '0;
    end
    else if (i_we)
    begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rdata <= '0;
    else
      o_rdata <= mem_ff[i_raddr];
  end
endmodule : pmd_result_mem

// *** design/pmd_power_mode_mgr.sv ***
// pmd_power_mode_mgr: power-level downshift, self-test control, button counts.
// assumes a register port fed by the serial front end on i_clk_sys, an
// activity strobe from the navigation core on the same clock, a raw switch pin.
`timescale 1ns/1ps
module pmd_power_mode_mgr #(
  parameter int RUN_FRAME_TICKS = pmd_pkg::RUN_FRAME_TICKS,
  parameter int HIB_TICK_CYCLES = pmd_pkg::HIB_TICK_CYCLES,
  parameter int SELFTEST_CYCLES = pmd_pkg::SELFTEST_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire pmd_pkg::pmd_reg_req_t i_reg_req,
  input wire logic i_activity,
  input wire logic i_button,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic [1:0] o_power_mode,
  output logic o_frame_pulse,
  output logic o_selftest_busy
);
  localparam int CORE_DIV = pmd_pkg::CORE_DIV;

  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp8

  function automatic logic [7:0] sig_byte(input logic [1:0] idx);
    case (idx)
      2'h0: sig_byte = pmd_pkg::SIG_BYTE0;
      2'h1: sig_byte = pmd_pkg::SIG_BYTE1;
      2'h2: sig_byte = pmd_pkg::SIG_BYTE2;
      default: sig_byte = pmd_pkg::SIG_BYTE3;
    endcase
  endfunction : sig_byte

  // register port
  logic [7:0] run_tmo_ff, r1_per_ff, r1_tmo_ff, r2_per_ff, r2_tmo_ff, r3_per_ff;
  pmd_pkg::pmd_st_t st_state_ff;
  logic acc_ok;
  logic wr_en;
  logic st_go;
  logic btn_wr;
  // accesses during the self-test are dropped; host must stay off the port
  assign acc_ok = (st_state_ff == pmd_pkg::ST_IDLE);
  assign wr_en = i_reg_req.wr && acc_ok;
  assign st_go = wr_en && (i_reg_req.addr == pmd_pkg::ADDR_SELFTEST) &&
                 i_reg_req.wdata[pmd_pkg::SELFTEST_GO_BIT];
  assign btn_wr = wr_en && (i_reg_req.addr == pmd_pkg::ADDR_BUTTON);

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      run_tmo_ff <= pmd_pkg::RST_RUN_TMO;
      r1_per_ff <= pmd_pkg::RST_R1_PER;
      r1_tmo_ff <= pmd_pkg::RST_R1_TMO;
      r2_per_ff <= pmd_pkg::RST_R2_PER;
      r2_tmo_ff <= pmd_pkg::RST_R2_TMO;
      r3_per_ff <= pmd_pkg::RST_R3_PER;
    end
    else if (wr_en)
    begin
      case (i_reg_req.addr)
        pmd_pkg::ADDR_RUN_TMO: run_tmo_ff <= i_reg_req.wdata;
        pmd_pkg::ADDR_R1_PER: r1_per_ff <= i_reg_req.wdata;
        pmd_pkg::ADDR_R1_TMO: r1_tmo_ff <= i_reg_req.wdata;
        pmd_pkg::ADDR_R2_PER: r2_per_ff <= i_reg_req.wdata;
        pmd_pkg::ADDR_R2_TMO: r2_tmo_ff <= i_reg_req.wdata;
        pmd_pkg::ADDR_R3_PER: r3_per_ff <= i_reg_req.wdata;
        default: ;
      endcase
    end
  end

  // button: two-stage sync, then edge detect on the second stage
  logic btn_s1_ff, btn_s2_ff, btn_d_ff;
  logic [1:0] rise_cnt_ff, fall_cnt_ff;
  logic btn_rise, btn_fall;
  assign btn_rise = btn_s2_ff && !btn_d_ff;
  assign btn_fall = !btn_s2_ff && btn_d_ff;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      btn_s1_ff <= 1'b0;
      btn_s2_ff <= 1'b0;
      btn_d_ff <= 1'b0;
    end
    else
    begin
      btn_s1_ff <= i_button;
      btn_s2_ff <= btn_s1_ff;
      btn_d_ff <= btn_s2_ff;
    end
  end

  // an edge in the clearing cycle counts as the first of the new run
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rise_cnt_ff <= 2'h0;
      fall_cnt_ff <= 2'h0;
    end
    else
    begin
      if (btn_wr)
        rise_cnt_ff <= {1'b0, btn_rise};
      else if (btn_rise)
        rise_cnt_ff <= rise_cnt_ff + 2'h1;
      if (btn_wr)
        fall_cnt_ff <= {1'b0, btn_fall};
      else if (btn_fall)
        fall_cnt_ff <= fall_cnt_ff + 2'h1;
    end
  end

  // self-test sequencer; results land in the result store when time is up
  logic [31:0] st_cnt_ff;
  logic [1:0] st_idx_ff;
  logic mem_we_ff;
  logic [1:0] mem_waddr_ff;
  logic [7:0] mem_wdata_ff;
  logic [7:0] mem_rdata;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_state_ff <= pmd_pkg::ST_IDLE;
      st_cnt_ff <= 32'h0;
      st_idx_ff <= 2'h0;
    end
    else
    begin
      case (st_state_ff)
        pmd_pkg::ST_IDLE:
        begin
          st_cnt_ff <= 32'h0;
          st_idx_ff <= 2'h0;
          if (st_go)
            st_state_ff <= pmd_pkg::ST_BUSY;
        end
        pmd_pkg::ST_BUSY:
        begin
          st_cnt_ff <= st_cnt_ff + 32'h1;
          if (st_cnt_ff == 32'(SELFTEST_CYCLES - 1))
            st_state_ff <= pmd_pkg::ST_WRITE;
        end
        pmd_pkg::ST_WRITE:
        begin
          st_idx_ff <= st_idx_ff + 2'h1;
          if (st_idx_ff == 2'h3)
            st_state_ff <= pmd_pkg::ST_IDLE;
        end
        default: st_state_ff <= pmd_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mem_we_ff <= 1'b0;
      mem_waddr_ff <= 2'h0;
      mem_wdata_ff <= 8'h00;
    end
    else
    begin
      mem_we_ff <= (st_state_ff == pmd_pkg::ST_WRITE);
      mem_waddr_ff <= st_idx_ff;
      mem_wdata_ff <= sig_byte(st_idx_ff);
    end
  end

  pmd_result_mem #(.WIDTH(8), .DEPTH(4), .AW(2)) u_result_mem (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_we(mem_we_ff),
    .i_waddr(mem_waddr_ff),
    .i_wdata(mem_wdata_ff),
    .i_raddr(i_reg_req.addr[1:0]),
    .o_rdata(mem_rdata)
  );

  // timebases: 25 MHz core tick and free-running 100 Hz hibernate tick
  logic [2:0] core_div_ff;
  logic [31:0] hib_cnt_ff;
  logic core_tick, hib_tick;
  assign core_tick = (core_div_ff == 3'(CORE_DIV - 1));
  assign hib_tick = (hib_cnt_ff == 32'(HIB_TICK_CYCLES - 1));

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      core_div_ff <= 3'h0;
      hib_cnt_ff <= 32'h0;
    end
    else
    begin
      core_div_ff <= core_tick ? 3'h0 : core_div_ff + 3'h1;
      hib_cnt_ff <= hib_tick ? 32'h0 : hib_cnt_ff + 32'h1;
    end
  end

  // power levels
  pmd_pkg::pmd_mode_t mode_ff;
  logic [31:0] run_frm_cnt_ff;
  logic [7:0] rest_cnt_ff;
  logic [15:0] idle_cnt_ff;
  logic [7:0] per_val;
  logic [15:0] idle_limit;
  logic run_frame, rest_frame, frame_evt, step;

  always_comb
  begin
    case (mode_ff)
      pmd_pkg::MODE_SLEEP1: per_val = clamp8(r1_per_ff, pmd_pkg::PER_MIN,
                                             pmd_pkg::PER_MAX);
      pmd_pkg::MODE_SLEEP2: per_val = clamp8(r2_per_ff, pmd_pkg::PER_MIN,
                                             pmd_pkg::PER_MAX);
      default: per_val = clamp8(r3_per_ff, pmd_pkg::PER_MIN,
                                pmd_pkg::PER_MAX);
    endcase
  end

  always_comb
  begin
    case (mode_ff)
      pmd_pkg::MODE_RUN: idle_limit = 16'(clamp8(run_tmo_ff, pmd_pkg::RUN_TMO_MIN,
                                      pmd_pkg::TMO_MAX) * pmd_pkg::RUN_MULT);
      pmd_pkg::MODE_SLEEP1: idle_limit = 16'(clamp8(r1_tmo_ff, pmd_pkg::REST_TMO_MIN,
                                         pmd_pkg::TMO_MAX) * pmd_pkg::R1_MULT);
      default: idle_limit = 16'(clamp8(r2_tmo_ff, pmd_pkg::REST_TMO_MIN,
                                pmd_pkg::TMO_MAX) * pmd_pkg::R2_MULT);
    endcase
  end

  assign run_frame = (mode_ff == pmd_pkg::MODE_RUN) && core_tick &&
                     (run_frm_cnt_ff == 32'(RUN_FRAME_TICKS - 1));
  // at-or-past, so a period cut mid-level cannot let the count wrap
  assign rest_frame = (mode_ff != pmd_pkg::MODE_RUN) && hib_tick &&
                      (rest_cnt_ff >= per_val);
  assign frame_evt = run_frame || rest_frame;
  // level three is the floor; it only keeps framing
  assign step = frame_evt && !i_activity && (mode_ff != pmd_pkg::MODE_SLEEP3) &&
                (idle_cnt_ff + 16'h1 >= idle_limit);

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      mode_ff <= pmd_pkg::MODE_RUN;
    else if (i_activity)
      mode_ff <= pmd_pkg::MODE_RUN;
    else if (step)
      mode_ff <= pmd_pkg::pmd_mode_t'(mode_ff + 2'h1);
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      idle_cnt_ff <= 16'h0;
    else if (i_activity || step)
      idle_cnt_ff <= 16'h0;
    else if (frame_evt && mode_ff != pmd_pkg::MODE_SLEEP3)
      idle_cnt_ff <= idle_cnt_ff + 16'h1;
  end

  // frame timers restart on any level change so each level starts clean
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      run_frm_cnt_ff <= 32'h0;
      rest_cnt_ff <= 8'h0;
    end
    else if (i_activity || step)
    begin
      run_frm_cnt_ff <= 32'h0;
      rest_cnt_ff <= 8'h0;
    end
    else
    begin
      if (mode_ff == pmd_pkg::MODE_RUN && core_tick)
        run_frm_cnt_ff <= run_frame ? 32'h0 : run_frm_cnt_ff + 32'h1;
      if (mode_ff != pmd_pkg::MODE_RUN && hib_tick)
        rest_cnt_ff <= rest_frame ? 8'h0 : rest_cnt_ff + 8'h1;
    end
  end

  // outputs and read path; the result store adds one cycle, so all reads take two
  logic rd_pend_ff;
  logic [7:0] rd_addr_ff;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= 8'h00;
    end
    else
    begin
      rd_pend_ff <= i_reg_req.rd && acc_ok;
      rd_addr_ff <= i_reg_req.addr;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= rd_pend_ff;
      if (rd_addr_ff >= pmd_pkg::ADDR_RESULT0 && rd_addr_ff <= pmd_pkg::ADDR_RESULT3)
        o_reg_rdata <= mem_rdata;
      else
      begin
        case (rd_addr_ff)
          pmd_pkg::ADDR_BUTTON: o_reg_rdata <= {rise_cnt_ff, fall_cnt_ff, 3'h0,
                                                btn_s2_ff};
          pmd_pkg::ADDR_RUN_TMO: o_reg_rdata <= run_tmo_ff;
          pmd_pkg::ADDR_R1_PER: o_reg_rdata <= r1_per_ff;
          pmd_pkg::ADDR_R1_TMO: o_reg_rdata <= r1_tmo_ff;
          pmd_pkg::ADDR_R2_PER: o_reg_rdata <= r2_per_ff;
          pmd_pkg::ADDR_R2_TMO: o_reg_rdata <= r2_tmo_ff;
          pmd_pkg::ADDR_R3_PER: o_reg_rdata <= r3_per_ff;
          default: o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_power_mode <= 2'b00;
      o_frame_pulse <= 1'b0;
      o_selftest_busy <= 1'b0;
    end
    else
    begin
      o_power_mode <= mode_ff;
      o_frame_pulse <= frame_evt;
      o_selftest_busy <= (st_state_ff != pmd_pkg::ST_IDLE);
    end
  end

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  st_start_a: assert property (st_go |=>
    st_state_ff == pmd_pkg::ST_BUSY ##1 o_selftest_busy)
    else $error("self-test did not start");
  st_length_a: assert property ((st_state_ff == pmd_pkg::ST_BUSY && st_cnt_ff ==
    32'(SELFTEST_CYCLES - 1)) |=> st_state_ff == pmd_pkg::ST_WRITE ##4
    st_state_ff == pmd_pkg::ST_IDLE)
    else $error("self-test length wrong");
  sig_write_a: assert property (mem_we_ff |-> mem_wdata_ff == sig_byte(mem_waddr_ff))
    else $error("wrong signature byte");
  btn_rise_a: assert property ((btn_rise && !btn_wr) |=>
    rise_cnt_ff == $past(rise_cnt_ff) + 2'h1)
    else $error("rise count missed");
  btn_fall_a: assert property ((btn_fall && !btn_wr) |=>
    fall_cnt_ff == $past(fall_cnt_ff) + 2'h1)
    else $error("fall count missed");
  btn_clear_a: assert property ((btn_wr && !btn_rise && !btn_fall) |=>
    rise_cnt_ff == 2'h0 && fall_cnt_ff == 2'h0)
    else $error("counts not restarted");
  run_drop_a: assert property ((mode_ff == pmd_pkg::MODE_RUN && step) |=>
    mode_ff == pmd_pkg::MODE_SLEEP1 ##1 o_power_mode == 2'b01)
    else $error("run did not drop");
  rest_period_a: assert property (rest_cnt_ff <= pmd_pkg::PER_MAX)
    else $error("rest period out of range");
  wake_run_a: assert property (i_activity |=> mode_ff == pmd_pkg::MODE_RUN &&
    idle_cnt_ff == 16'h0 && rest_cnt_ff == 8'h0)
    else $error("activity did not wake");
  btn_level_a: assert property ((rd_pend_ff && rd_addr_ff == pmd_pkg::ADDR_BUTTON) |=>
    o_reg_rdata[pmd_pkg::BTN_LEVEL_BIT] == $past(btn_s2_ff))
    else $error("button level wrong");

  st_done_c: cover property (st_state_ff == pmd_pkg::ST_WRITE ##4 st_state_ff == pmd_pkg::ST_IDLE);
  deep_sleep_c: cover property (mode_ff == pmd_pkg::MODE_SLEEP3);
  wake_c: cover property (mode_ff == pmd_pkg::MODE_SLEEP2 && i_activity);
  btn_wrap_c: cover property (rise_cnt_ff == 2'h3 && btn_rise && !btn_wr);
endmodule : pmd_power_mode_mgr

// *** testbench/pmd_host_model.sv ***
// pmd_host_model: behavioural host driving the register request port.
// assumes requests are taken on the rising edge; drives at the falling edge.
`timescale 1ns/1ps
module pmd_host_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  input wire logic i_busy,
  output pmd_pkg::pmd_reg_req_t o_reg_req
);
  logic [7:0] cfg_a [0:9] = '{8'h29, 8'h11, 8'h60, 8'h61, 8'h72, 8'h63, 8'h75, 8'h76, 8'h7c,
    8'h7e};
  logic [7:0] cfg_d [0:9] = '{8'hc1, 8'h59, 8'hff, 8'h88, 8'haa, 8'hc4, 8'h20, 8'h05, 8'h04,
    8'hff};

  initial o_reg_req = '0;

  task automatic send(input logic wr, input logic rd, input logic [7:0] a,
                      input logic [7:0] d, output logic ok);
    int n;
    n = 0;
    // hold off while busy is high, for at most 400 cycles; then access anyway
    while (i_busy !== 1'b0 && n < 400)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    ok = (n < 400);
    o_reg_req.wr = wr;
    o_reg_req.rd = rd;
    o_reg_req.addr = a;
    o_reg_req.wdata = d;
    @(negedge i_clk_sys);
    // idle fields changed so stale values are never mistaken for a request
    o_reg_req.wr = 1'b0;
    o_reg_req.rd = 1'b0;
    o_reg_req.addr = ~a;
    o_reg_req.wdata = ~d;
    // one idle edge so a following call never re-raises a strobe in this step
    @(negedge i_clk_sys);
  endtask : send

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    send(1'b0, 1'b1, a, 8'h00, ok);
    while (i_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    if (i_rvalid === 1'b1)
      d = i_rdata;
    else
      ok = 1'b0;
  endtask : read_reg

  task automatic run_selftest(output logic [31:0] res, output logic ok);
    logic k;
    logic [7:0] b;
    ok = 1'b1;
    res = 32'h0;
    send(1'b1, 1'b0, 8'h3a, 8'h5a, k);
    ok &= k;
    for (int i = 0; i < 10; i++)
    begin
      send(1'b1, 1'b0, cfg_a[i], cfg_d[i], k);
      ok &= k;
    end
    send(1'b1, 1'b0, 8'h10, 8'h01, k);
    ok &= k;
    repeat (3) @(negedge i_clk_sys);
    for (int i = 0; i < 4; i++)
    begin
      read_reg(8'h0c + 8'(i), b, k);
      ok &= k;
      res = {res[23:0], b};
    end
  endtask : run_selftest
endmodule : pmd_host_model

// *** testbench/pmd_power_mode_mgr_tb.sv ***
// pmd_power_mode_mgr_tb: register, button, self-test and downshift checks.
// assumes shortened counts: 20 core ticks a run frame, 16 cycles a 10 ms tick.
`timescale 1ns/1ps
module pmd_power_mode_mgr_tb;
  localparam int ST_CYC = 50;
  logic clk, resetn, activity, button, rvalid, frame, busy, ok;
  logic [7:0] rdata, d;
  logic [1:0] mode;
  logic [31:0] res;
  pmd_pkg::pmd_reg_req_t req;
  int n_fail = 0;
  int checked = 0;
  int busy_len = 0;
  logic [7:0] rst_a [0:8] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h12, 8'h10, 8'h20};
  logic [7:0] rst_d [0:8] = '{8'h04, 8'h01, 8'h1f, 8'h09, 8'h2f, 8'h31, 8'h00, 8'h00, 8'h00};

  pmd_power_mode_mgr #(.RUN_FRAME_TICKS(20), .HIB_TICK_CYCLES(16), .SELFTEST_CYCLES(ST_CYC))
  dut_u (.i_clk_sys(clk), .i_resetn(resetn), .i_reg_req(req), .i_activity(activity),
    .i_button(button), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_power_mode(mode),
    .o_frame_pulse(frame), .o_selftest_busy(busy));

  pmd_host_model host_u (.i_clk_sys(clk), .i_rdata(rdata), .i_rvalid(rvalid), .i_busy(busy),
    .o_reg_req(req));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // sampled off the launching edge so the count never races the output
  always @(negedge clk)
    if (busy === 1'b1)
      busy_len++;

  task automatic test_done();
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic stop_if(input logic good);
    if (good !== 1'b1)
    begin
      n_fail++;
      test_done();
    end
  endtask : stop_if

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_u.send(1'b1, 1'b0, a, v, ok);
    stop_if(ok);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_u.read_reg(a, d, ok);
    stop_if(ok);
    chk8(d, exp);
  endtask : rd_chk

  // counts frames of one level; cap > 0 stops after cap frames in that level
  task automatic level(input logic [1:0] lv, input int nf, input int per, input int cap);
    int n, c, gap, t;
    n = 0;
    c = 0;
    gap = 0;
    t = 0;
    while (mode === lv && t < 20000 && !(cap > 0 && n == cap))
    begin
      @(negedge clk);
      t++;
      c++;
      if (frame === 1'b1)
      begin
        n++;
        if (n > 1)
          gap = c;
        c = 0;
      end
    end
    stop_if(t < 20000);
    chk8(8'(n), 8'(nf));
    chk8(8'(gap), 8'(per));
    chk8({6'h0, mode}, {6'h0, (cap > 0) ? lv : lv + 2'd1});
  endtask : level

  initial
  begin
    resetn = 1'b0;
    activity = 1'b0;
    button = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 9; i++) rd_chk(rst_a[i], rst_d[i]);
    wr(8'h13, 8'h5a);
    rd_chk(8'h13, 8'h5a);
    for (int i = 0; i < 3; i++)
    begin
      button = ~button;
      repeat (6) @(negedge clk);
    end
    rd_chk(8'h12, 8'h91);
    wr(8'h12, 8'hff);
    rd_chk(8'h12, 8'h01);
    button = 1'b0;
    repeat (6) @(negedge clk);
    rd_chk(8'h12, 8'h10);
    // a zero in the go bit must not start the test
    wr(8'h10, 8'h00);
    repeat (3) @(negedge clk);
    chk8({7'h0, busy}, 8'h00);
    host_u.run_selftest(res, ok);
    stop_if(ok);
    // busy covers the test time plus the four result stores
    chk8(8'(busy_len), 8'(ST_CYC + 4));
    for (int i = 0; i < 4; i++)
      chk8(res[31 - 8 * i -: 8], 8'(32'h3e5ca424 >> (24 - 8 * i)));
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    rd_chk(8'h0c, 8'h00);
    // out-of-range settings exercise the clamps: 0 and 0xff
    wr(8'h13, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h15, 8'h00);
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h00);
    wr(8'h18, 8'hff);
    activity = 1'b1;
    @(negedge clk);
    activity = 1'b0;
    repeat (2) @(negedge clk);
    level(2'd0, 16, 100, 0);
    level(2'd1, 16, 32, 0);
    level(2'd2, 128, 32, 0);
    level(2'd3, 3, 3856, 3);
    activity = 1'b1;
    @(negedge clk);
    activity = 1'b0;
    repeat (2) @(negedge clk);
    chk8({6'h0, mode}, 8'h00);
    level(2'd0, 16, 100, 0);
    test_done();
  end
endmodule : pmd_power_mode_mgr_tb
